// *** rtl/irr_defs.svh ***
`ifndef IRR_DEFS_SVH
`define IRR_DEFS_SVH

// =====================================================================
// register offsets
`define IRR_ADDR_CFG       16'h5340
`define IRR_ADDR_CAR       16'h5342
`define IRR_ADDR_LCNT      16'h5344
`define IRR_ADDR_EVT       16'h5346

// =====================================================================
// field positions
`define IRR_CFG_EN         0
`define IRR_CFG_DIR        1
`define IRR_CFG_LC_LSB     8
`define IRR_CFG_CG_LSB     12
`define IRR_CAR_H_LSB      0
`define IRR_CAR_L_LSB      8
`define IRR_LCNT_DT        0
`define IRR_LCNT_LEN_LSB   8
`define IRR_EVT_EN_LSB     0
`define IRR_EVT_FLAG_LSB   8
`define IRR_EV_UF          0
`define IRR_EV_RISE        1
`define IRR_EV_FALL        2

// =====================================================================
// reset values and codes
`define IRR_RST_WORD       16'h0000
`define IRR_RST_DIV        4'h0
`define IRR_RST_LEN6       6'h00
`define IRR_RST_LEN8       8'h00
`define IRR_RST_EV         3'h0
`define IRR_DIV_RESERVED   4'hf
`define IRR_PRESCALE_W     14

`endif

// *** rtl/irr_pkg.sv ***
package irr_pkg;

    typedef logic [15:0] irr_word_t;

    typedef enum logic {
        IRR_CAR_HIGH,
        IRR_CAR_LOW
    } irr_phase_e;

endpackage

// *** rtl/irr_sync_edge.sv ***
`timescale 1ns/1ns
`default_nettype none

module irr_sync_edge (
    // clock and reset
    input  wire logic clock,
    input  wire logic srst,
    // pin side
    input  wire logic async_in,
    // result
    output logic      level,
    output logic      rise,
    output logic      fall
);

    logic meta_reg;
    logic sync_reg;
    logic prev_reg;

    // =================================================================
    // two flip-flop synchroniser
    always_ff @(posedge clock) begin
        if (srst) begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    // =================================================================
    // edge detection on the synchronised level
    always_ff @(posedge clock) begin
        if (srst) begin
            prev_reg <= 1'b1;
        end else begin
            prev_reg <= sync_reg;
        end
    end

    assign level = sync_reg;
    assign rise  = sync_reg & ~prev_reg;
    assign fall  = ~sync_reg & prev_reg;

endmodule

`default_nettype wire

// *** rtl/irr_len_counter.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "irr_defs.svh"

module irr_len_counter (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       srst,
    // control
    input  wire logic       load,
    input  wire logic [7:0] load_value,
    input  wire logic       tick,
    input  wire logic       run,
    // status
    output logic [7:0]      count,
    output logic            underflow
);

    logic [7:0] count_reg;
    logic       active_reg;
    logic       uf_reg;

    // =================================================================
    // down-counter, stops at zero and pulses underflow
    always_ff @(posedge clock) begin
        if (srst) begin
            count_reg  <= `IRR_RST_LEN8;
            active_reg <= 1'b0;
            uf_reg     <= 1'b0;
        end else begin
            uf_reg <= 1'b0;
            if (load) begin
                count_reg  <= load_value;
                active_reg <= 1'b1;
            end else if (run && tick && active_reg) begin
                if (count_reg <= 8'h01) begin
                    count_reg  <= 8'h00;
                    active_reg <= 1'b0;
                    uf_reg     <= 1'b1;
                end else begin
                    count_reg <= count_reg - 8'h01;
                end
            end
        end
    end

    assign count     = count_reg;
    assign underflow = uf_reg;

endmodule

`default_nettype wire

// *** rtl/irr_remote_unit.sv ***
// Summary of operation
// - enabled transmit: data bit ANDed with carrier out
// - receive mode: data bit follows input level
// - data bit read/write, 1 high, resets 0
// - input falling edge sets flag bit 10 while the unit is enabled
// - input rising edge sets flag bit 9 while the unit is enabled
// - length counter underflow sets flag bit 8
// - flags reset 0, write one clears
// - enables at bits 2..0, reset 0
// - enabled flag raises request same cycle
// - disabled event recorded but not forwarded
// - event control register 16 bits at 0x5346
// - length counter stops at zero, raises underflow
// - enable starts operation per direction bit
`timescale 1ns/1ns
`default_nettype none
`include "irr_defs.svh"

module irr_remote_unit (
    // clock and reset
    input  wire logic        CLOCK,
    input  wire logic        SRST,
    // register port
    input  wire logic [15:0] REG_ADDR,
    input  wire logic [15:0] REG_WDATA,
    input  wire logic        REG_WRITE,
    input  wire logic        REG_READ,
    output logic      [15:0] REG_RDATA,
    // infrared pins
    input  wire logic        IR_INPUT_PIN,
    output logic             IR_OUTPUT_PIN,
    // interrupt request
    output logic             IRQ
);

    // =================================================================
    // declarations
    logic [3:0]  cg_div_reg;
    logic [3:0]  lc_div_reg;
    logic        ir_direction_select_reg;
    logic        ir_unit_enable_reg;
    logic [5:0]  car_high_len_reg;
    logic [5:0]  car_low_len_reg;
    logic        ir_data_bit_reg;
    logic [2:0]  flags_reg;
    logic [2:0]  irq_en_reg;
    logic [2:0]  flags_next;
    logic [13:0] prescale_reg;
    logic [5:0]  car_count_reg;
    logic        out_reg;
    irr_pkg::irr_phase_e phase_reg;
    irr_pkg::irr_word_t  rdata_reg;
    irr_pkg::irr_word_t  rdata_next;

    logic        wr_cfg;
    logic        wr_car;
    logic        wr_lcnt;
    logic        wr_evt;
    logic        cg_tick;
    logic        lc_tick;
    logic        in_level;
    logic        in_rise;
    logic        in_fall;
    logic [7:0]  len_count;
    logic        len_underflow;
    logic        carrier_high;
    logic        rx_active;
    logic        tx_active;
    logic [2:0]  events;

    // =================================================================
    // helpers
    function automatic logic div_tick(input logic [13:0] cnt, input logic [3:0] sel);
        logic [14:0] m;
        m = (15'h0001 << sel) - 15'h0001;
        return (sel != `IRR_DIV_RESERVED) && ((cnt & m[13:0]) == m[13:0]);
    endfunction

    function automatic logic addr_hit(input logic [15:0] a, input logic [15:0] off);
        return a == off;
    endfunction

    // =================================================================
    // address decode
    assign wr_cfg  = REG_WRITE && addr_hit(REG_ADDR, `IRR_ADDR_CFG);
    assign wr_car  = REG_WRITE && addr_hit(REG_ADDR, `IRR_ADDR_CAR);
    assign wr_lcnt = REG_WRITE && addr_hit(REG_ADDR, `IRR_ADDR_LCNT);
    assign wr_evt  = REG_WRITE && addr_hit(REG_ADDR, `IRR_ADDR_EVT);

    assign tx_active = ir_unit_enable_reg && !ir_direction_select_reg;
    assign rx_active = ir_unit_enable_reg && ir_direction_select_reg;

    // =================================================================
    // configuration register
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            cg_div_reg              <= `IRR_RST_DIV;
            lc_div_reg              <= `IRR_RST_DIV;
            ir_direction_select_reg <= 1'b0;
            ir_unit_enable_reg      <= 1'b0;
        end else if (wr_cfg) begin
            cg_div_reg              <= REG_WDATA[`IRR_CFG_CG_LSB +: 4];
            lc_div_reg              <= REG_WDATA[`IRR_CFG_LC_LSB +: 4];
            ir_direction_select_reg <= REG_WDATA[`IRR_CFG_DIR];
            ir_unit_enable_reg      <= REG_WDATA[`IRR_CFG_EN];
        end
    end

    // =================================================================
    // carrier length register
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            car_high_len_reg <= `IRR_RST_LEN6;
            car_low_len_reg  <= `IRR_RST_LEN6;
        end else if (wr_car) begin
            car_high_len_reg <= REG_WDATA[`IRR_CAR_H_LSB +: 6];
            car_low_len_reg  <= REG_WDATA[`IRR_CAR_L_LSB +: 6];
        end
    end

    // =================================================================
    // clock prescaler, held at zero while stopped
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            prescale_reg <= 14'h0000;
        end else if (!ir_unit_enable_reg) begin
            prescale_reg <= 14'h0000;
        end else begin
            prescale_reg <= prescale_reg + 14'h0001;
        end
    end

    assign cg_tick = ir_unit_enable_reg && div_tick(prescale_reg, cg_div_reg);
    assign lc_tick = ir_unit_enable_reg && div_tick(prescale_reg, lc_div_reg);

    // =================================================================
    // carrier generator: high section then low section
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            phase_reg     <= irr_pkg::IRR_CAR_HIGH;
            car_count_reg <= `IRR_RST_LEN6;
        end else if (!ir_unit_enable_reg) begin
            phase_reg     <= irr_pkg::IRR_CAR_HIGH;
            car_count_reg <= `IRR_RST_LEN6;
        end else if (cg_tick) begin
            unique case (phase_reg)
                irr_pkg::IRR_CAR_HIGH: begin
                    if (car_count_reg >= car_high_len_reg) begin
                        phase_reg     <= irr_pkg::IRR_CAR_LOW;
                        car_count_reg <= 6'h00;
                    end else begin
                        car_count_reg <= car_count_reg + 6'h01;
                    end
                end
                irr_pkg::IRR_CAR_LOW: begin
                    if (car_count_reg >= car_low_len_reg) begin
                        phase_reg     <= irr_pkg::IRR_CAR_HIGH;
                        car_count_reg <= 6'h00;
                    end else begin
                        car_count_reg <= car_count_reg + 6'h01;
                    end
                end
            endcase
        end
    end

    assign carrier_high = (phase_reg == irr_pkg::IRR_CAR_HIGH);

    // =================================================================
    // input pin synchroniser and edges
    irr_sync_edge u_sync (
        .clock    (CLOCK),
        .srst     (SRST),
        .async_in (IR_INPUT_PIN),
        .level    (in_level),
        .rise     (in_rise),
        .fall     (in_fall)
    );

    // =================================================================
    // data length counter
    irr_len_counter u_len (
        .clock      (CLOCK),
        .srst       (SRST),
        .load       (wr_lcnt),
        .load_value (REG_WDATA[`IRR_LCNT_LEN_LSB +: 8]),
        .tick       (lc_tick),
        .run        (ir_unit_enable_reg),
        .count      (len_count),
        .underflow  (len_underflow)
    );

    // =================================================================
    // data bit: written by software, tracks input in receive mode
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            ir_data_bit_reg <= 1'b0;
        end else if (rx_active) begin
            ir_data_bit_reg <= in_level;
        end else if (wr_lcnt) begin
            ir_data_bit_reg <= REG_WDATA[`IRR_LCNT_DT];
        end
    end

    // =================================================================
    // modulated output pin
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            out_reg <= 1'b0;
        end else begin
            out_reg <= tx_active && ir_data_bit_reg && carrier_high;
        end
    end

    assign IR_OUTPUT_PIN = out_reg;

    // =================================================================
    // event flags, set wins over write-one clear
    assign events[`IRR_EV_UF]   = len_underflow;
    assign events[`IRR_EV_RISE] = ir_unit_enable_reg && in_rise;
    assign events[`IRR_EV_FALL] = ir_unit_enable_reg && in_fall;

    always_comb begin
        flags_next = flags_reg;
        if (wr_evt) begin
            flags_next = flags_reg & ~REG_WDATA[`IRR_EVT_FLAG_LSB +: 3];
        end
        flags_next = flags_next | events;
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            flags_reg <= `IRR_RST_EV;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // =================================================================
    // interrupt enables
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            irq_en_reg <= `IRR_RST_EV;
        end else if (wr_evt) begin
            irq_en_reg <= REG_WDATA[`IRR_EVT_EN_LSB +: 3];
        end
    end

    assign IRQ = |(flags_reg & irq_en_reg);

    // =================================================================
    // read data, one cycle after the strobe
    always_comb begin
        rdata_next = `IRR_RST_WORD;
        unique case (REG_ADDR)
            `IRR_ADDR_CFG: begin
                rdata_next = {cg_div_reg, lc_div_reg, 6'h00,
                              ir_direction_select_reg, ir_unit_enable_reg};
            end
            `IRR_ADDR_CAR: begin
                rdata_next = {2'h0, car_low_len_reg, 2'h0, car_high_len_reg};
            end
            `IRR_ADDR_LCNT: begin
                rdata_next = {len_count, 7'h00, ir_data_bit_reg};
            end
            `IRR_ADDR_EVT: begin
                rdata_next = {5'h00, flags_reg, 5'h00, irq_en_reg};
            end
            default: begin
                rdata_next = `IRR_RST_WORD;
            end
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            rdata_reg <= `IRR_RST_WORD;
        end else if (REG_READ) begin
            rdata_reg <= rdata_next;
        end else begin
            rdata_reg <= `IRR_RST_WORD;
        end
    end

    assign REG_RDATA = rdata_reg;

    // =================================================================
    // assertions
    default clocking @(posedge CLOCK); endclocking
    default disable iff (SRST);

    property p_tx_output;
        tx_active |=> IR_OUTPUT_PIN == $past(ir_data_bit_reg && carrier_high);
    endproperty
    a_tx_output: assert property (p_tx_output) else $error("tx output wrong");

    property p_rx_tracks;
        rx_active |=> ir_data_bit_reg == $past(in_level);
    endproperty
    a_rx_tracks: assert property (p_rx_tracks) else $error("rx data bit wrong");

    property p_data_write;
        wr_lcnt && !rx_active |=> ir_data_bit_reg == $past(REG_WDATA[0]);
    endproperty
    a_data_write: assert property (p_data_write) else $error("data bit write lost");

    property p_fall_flag;
        ir_unit_enable_reg && in_fall |=> flags_reg[2];
    endproperty
    a_fall_flag: assert property (p_fall_flag) else $error("fall flag not set");

    property p_rise_flag;
        ir_unit_enable_reg && in_rise |=> flags_reg[1];
    endproperty
    a_rise_flag: assert property (p_rise_flag) else $error("rise flag not set");

    property p_uf_flag;
        len_underflow |-> len_count == 8'h00 ##1 flags_reg[0];
    endproperty
    a_uf_flag: assert property (p_uf_flag) else $error("underflow flag not set");

    property p_clear_one;
        wr_evt && REG_WDATA[8] && !events[0] |=> !flags_reg[0];
    endproperty
    a_clear_one: assert property (p_clear_one) else $error("write one did not clear");

    property p_keep_zero;
        wr_evt && !REG_WDATA[10] && flags_reg[2] |=> flags_reg[2];
    endproperty
    a_keep_zero: assert property (p_keep_zero) else $error("write zero cleared flag");

    property p_enable_write;
        wr_evt |=> irq_en_reg == $past(REG_WDATA[2:0]);
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable write lost");

    property p_irq_same_cycle;
        $rose(flags_reg[1]) && irq_en_reg[1] |-> IRQ;
    endproperty
    a_irq_same_cycle: assert property (p_irq_same_cycle) else $error("irq late");

    property p_irq_masked;
        (flags_reg & irq_en_reg) == 3'h0 |-> !IRQ;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("masked event raised irq");

    property p_evt_read;
        REG_READ && REG_ADDR == `IRR_ADDR_EVT
            |=> REG_RDATA == {5'h00, $past(flags_reg), 5'h00, $past(irq_en_reg)};
    endproperty
    a_evt_read: assert property (p_evt_read) else $error("event read wrong");

    property p_stop_zero;
        len_count == 8'h00 && !wr_lcnt |=> len_count == 8'h00;
    endproperty
    a_stop_zero: assert property (p_stop_zero) else $error("counter left zero");

    property p_disabled_quiet;
        !ir_unit_enable_reg |=> !IR_OUTPUT_PIN;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("output while off");

    property p_irq_held;
        IRQ && !wr_evt |=> IRQ;
    endproperty
    a_irq_held: assert property (p_irq_held) else $error("irq dropped alone");

    c_tx_pulse: cover property (tx_active ##1 IR_OUTPUT_PIN);
    c_uf_irq: cover property (len_underflow ##1 IRQ);
    c_rx_fall: cover property (rx_active && in_fall ##1 IRQ);
    c_clear_set: cover property (wr_evt && REG_WDATA[9] && events[1]);

endmodule

`default_nettype wire

// *** tb/irr_ir_partner.sv ***
`timescale 1ns/1ns
`default_nettype none

// =====================================================================
// ir receiver module and led driver model
module irr_ir_partner (
    // clock
    input  wire logic       clock,
    // receiver side
    input  wire logic       rx_level,
    output logic            rx_pin,
    // led driver side
    input  wire logic       led_pin,
    input  wire logic       count_clr,
    output logic [7:0]      led_count
);
    // receiver output idles high, then follows the demodulated level
    initial rx_pin = 1'h1;
    always @(posedge clock) begin
        rx_pin <= rx_level;
    end

    // counts clock cycles with the led lit
    initial led_count = 8'h00;
    always @(posedge clock) begin
        if (count_clr) begin
            led_count <= 8'h00;
        end else if (led_pin) begin
            led_count <= led_count + 8'h01;
        end
    end
endmodule
`default_nettype wire

// *** tb/irr_remote_unit_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none

module irr_remote_unit_tb_top;
    logic        clock;
    logic        srst;
    logic [15:0] reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_write;
    logic        reg_read;
    logic [15:0] reg_rdata;
    logic        ir_in;
    logic        ir_out;
    logic        irq;
    logic        rx_level;
    logic        count_clr;
    logic [7:0]  led_count;
    int          n_errors;
    int          n_checks;

    // =================================================================
    // design and far side
    irr_remote_unit u_irr_remote_unit (
        .CLOCK         (clock),
        .SRST          (srst),
        .REG_ADDR      (reg_addr),
        .REG_WDATA     (reg_wdata),
        .REG_WRITE     (reg_write),
        .REG_READ      (reg_read),
        .REG_RDATA     (reg_rdata),
        .IR_INPUT_PIN  (ir_in),
        .IR_OUTPUT_PIN (ir_out),
        .IRQ           (irq)
    );

    irr_ir_partner u_irr_ir_partner (
        .clock     (clock),
        .rx_level  (rx_level),
        .rx_pin    (ir_in),
        .led_pin   (ir_out),
        .count_clr (count_clr),
        .led_count (led_count)
    );

    initial begin
        clock = 1'h0;
        forever #10 clock = ~clock;
    end

    // =================================================================
    // access and compare tasks
    task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_write <= 1'h1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'h0;
        #1;
    endtask

    task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
        @(posedge clock);
        reg_read <= 1'h1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'h0;
        #1;
        check_word(reg_rdata, exp);
    endtask

    // lit cycles over eight clocks
    task automatic led_chk(input logic [7:0] exp);
        @(posedge clock);
        count_clr <= 1'h1;
        @(posedge clock);
        count_clr <= 1'h0;
        repeat (8) @(posedge clock);
        #1;
        check_word({8'h00, led_count}, {8'h00, exp});
    endtask

    task automatic pin_set(input logic lvl);
        @(posedge clock);
        rx_level <= lvl;
        repeat (6) @(posedge clock);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        #(20 * 4000);
        n_errors++;
        complete_run();
    end

    // =================================================================
    // tests
    initial begin
        n_errors  = 0;
        n_checks  = 0;
        srst      = 1'h1;
        reg_addr  = 16'h0000;
        reg_wdata = 16'h0000;
        reg_write = 1'h0;
        reg_read  = 1'h0;
        rx_level  = 1'h1;
        count_clr = 1'h0;
        repeat (2) @(posedge clock);
        srst <= 1'h0;
        @(posedge clock);
        #1;
        check_bit(irq, 1'h0);
        rd_chk(16'h5346, 16'h0000);
        rd_chk(16'h5344, 16'h0000);
        rd_chk(16'h5348, 16'h0000);
        reg_wr(16'h5346, 16'hffff);
        rd_chk(16'h5346, 16'h0007);
        reg_wr(16'h5346, 16'h0000);
        rd_chk(16'h5346, 16'h0000);
        $display("test reset and register map done");

        reg_wr(16'h5344, 16'h2001);
        led_chk(8'h00);
        rd_chk(16'h5344, 16'h2001);
        reg_wr(16'h5340, 16'h0001);
        led_chk(8'h04);
        reg_wr(16'h5344, 16'h2000);
        led_chk(8'h00);
        repeat (40) @(posedge clock);
        rd_chk(16'h5346, 16'h0100);
        rd_chk(16'h5344, 16'h0000);
        check_bit(irq, 1'h0);
        reg_wr(16'h5346, 16'h0001);
        check_bit(irq, 1'h1);
        reg_wr(16'h5346, 16'h0101);
        check_bit(irq, 1'h0);
        rd_chk(16'h5346, 16'h0001);
        $display("test transmit and underflow done");

        reg_wr(16'h5340, 16'h0003);
        reg_wr(16'h5346, 16'h0700);
        reg_wr(16'h5346, 16'h0006);
        pin_set(1'h0);
        rd_chk(16'h5346, 16'h0406);
        check_bit(irq, 1'h1);
        rd_chk(16'h5344, 16'h0000);
        pin_set(1'h1);
        rd_chk(16'h5346, 16'h0606);
        rd_chk(16'h5344, 16'h0001);
        reg_wr(16'h5346, 16'h0006);
        rd_chk(16'h5346, 16'h0606);
        reg_wr(16'h5346, 16'h0406);
        rd_chk(16'h5346, 16'h0206);
        check_bit(irq, 1'h1);
        reg_wr(16'h5346, 16'h0200);
        check_bit(irq, 1'h0);
        rd_chk(16'h5346, 16'h0000);
        pin_set(1'h0);
        rd_chk(16'h5346, 16'h0400);
        check_bit(irq, 1'h0);
        reg_wr(16'h5346, 16'h0400);
        reg_wr(16'h5340, 16'h0002);
        pin_set(1'h1);
        rd_chk(16'h5346, 16'h0000);
        rd_chk(16'h5340, 16'h0002);
        reg_wr(16'h5342, 16'hffff);
        rd_chk(16'h5342, 16'h3f3f);
        reg_wr(16'h5342, 16'h0000);
        rd_chk(16'h5342, 16'h0000);
        $display("test receive and edge events done");
        complete_run();
    end
endmodule
`default_nettype wire
